// ==== inc/cts_pkg.sv ====
// constants for the capacitive touch sequencer
package cts_pkg;
  // register offsets
  localparam logic [3:0] ADDR_POWER = 4'h0;
  localparam logic [3:0] ADDR_PAD = 4'h1;
  localparam logic [3:0] ADDR_CMD = 4'h2;
  localparam logic [3:0] ADDR_SETTING = 4'h3;
  localparam logic [3:0] ADDR_CNT_HI = 4'h4;
  localparam logic [3:0] ADDR_CNT_LO = 4'h5;
  localparam logic [3:0] ADDR_INTEN = 4'h6;
  localparam logic [3:0] ADDR_INTRQ = 4'h7;
  // command codes
  localparam logic [7:0] CMD_ABORT = 8'h00;
  localparam logic [7:0] CMD_START = 8'h10;
  localparam logic [7:0] CMD_MANUAL = 8'h30;
  // field positions
  localparam int POWER_BYPASS_BIT = 2;
  localparam int POWER_LEVEL_BIT = 3;
  localparam int IRQ_DONE_BIT = 3;
  localparam int IRQ_OVF_BIT = 5;
  localparam int SET_DIS_LSB = 0;
  localparam int SET_THR_LSB = 2;
  // reset values
  localparam logic [7:0] POWER_RESET = 8'h00;
  localparam logic [7:0] PAD_RESET = 8'h00;
  localparam logic [4:0] SETTING_RESET = 5'h00;
  localparam logic [7:0] INTEN_RESET = 8'h00;
  localparam logic [7:0] INTRQ_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // timing
  localparam int CLOCK_MHZ = 100;
  localparam int TOUCH_CLOCK_KHZ = 25000;
  localparam logic [7:0] TOUCH_DIV = 8'(CLOCK_MHZ * 1000 / TOUCH_CLOCK_KHZ);
  localparam logic [7:0] DIS_SHORT = 8'h20;
  localparam logic [7:0] DIS_MID = 8'h40;
  localparam logic [7:0] DIS_LONG = 8'h80;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DISCHARGE = 2'b01,
    ST_HOLD = 2'b10,
    ST_CHARGE = 2'b11
  } cts_state_type;
endpackage : cts_pkg

// ==== design/cts_sequencer.sv ====
// capacitive touch sequencer: discharge, charge, count, flags, registers
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/10ps
module cts_sequencer (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic comp_trip_i,
  output logic [7:0] rd_data_o,
  output logic [7:0] pad_select_o,
  output logic discharge_o,
  output logic charge_o,
  output logic charge_step_o,
  output logic [2:0] threshold_sel_o,
  output logic bypass_o,
  output logic level_sel_o,
  output logic irq_o
);

  logic [7:0] power_q;
  logic [7:0] pad_q;
  logic [4:0] setting_q;
  logic [7:0] inten_q;
  logic [7:0] intrq_q;
  logic [15:0] count_q;
  logic [7:0] div_q;
  logic [7:0] dis_cnt_q;
  logic tick_q;
  logic comp_meta_q;
  logic comp_sync_q;
  cts_pkg::cts_state_type state_q;
  cts_pkg::cts_state_type state_d;
  logic cmd_wr;
  logic start_cmd;
  logic done_evt;
  logic ovf_evt;
  logic dis_end;
  logic count_step;

  // discharge length from setting bits 1:0; code 3 also gives the longest
  function automatic logic [7:0] dis_len(input logic [1:0] sel);
    case (sel)
      2'h0: dis_len = cts_pkg::DIS_SHORT;
      2'h1: dis_len = cts_pkg::DIS_MID;
      default: dis_len = cts_pkg::DIS_LONG;
    endcase
  endfunction : dis_len

  // register write decode, shared by the command and every stored register
  function automatic logic reg_hit(input logic wr, input logic [3:0] addr, input logic [3:0] offset);
    reg_hit = wr && (addr == offset);
  endfunction : reg_hit

  assign cmd_wr = reg_hit(wr_i, addr_i, cts_pkg::ADDR_CMD);
  assign start_cmd = cmd_wr && (wr_data_i == cts_pkg::CMD_START);
  assign dis_end = (state_q == cts_pkg::ST_DISCHARGE) && tick_q &&
                   (dis_cnt_q == dis_len(setting_q[cts_pkg::SET_DIS_LSB +: 2]) - 8'h01);
  assign done_evt = (state_q == cts_pkg::ST_CHARGE) && comp_sync_q && !cmd_wr;
  // counter and step pulse share one condition so the two never drift apart
  assign count_step = (state_q == cts_pkg::ST_CHARGE) && (state_d == cts_pkg::ST_CHARGE) && tick_q;
  assign ovf_evt = count_step && !cmd_wr && (count_q == 16'hFFFF);

  // comparator comes from the analog side, so two flops first
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      comp_meta_q <= 1'b0;
      comp_sync_q <= 1'b0;
    end else begin
      comp_meta_q <= comp_trip_i;
      comp_sync_q <= comp_meta_q;
    end
  end

  // touch clock as an enable pulse
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_q <= 8'h00;
      tick_q <= 1'b0;
    end else if (div_q == cts_pkg::TOUCH_DIV - 8'h01) begin
      div_q <= 8'h00;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 8'h01;
      tick_q <= 1'b0;
    end
  end

  // sequencer; a command write outranks any event in the same cycle
  always_comb begin
    state_d = state_q;
    if (cmd_wr) begin
      case (wr_data_i)
        cts_pkg::CMD_ABORT: state_d = cts_pkg::ST_IDLE;
        cts_pkg::CMD_MANUAL: state_d = cts_pkg::ST_HOLD;
        cts_pkg::CMD_START: begin
          if (state_q == cts_pkg::ST_HOLD) begin
            state_d = cts_pkg::ST_CHARGE;
          end else begin
            state_d = cts_pkg::ST_DISCHARGE;
          end
        end
        default: state_d = state_q;
      endcase
    end else begin
      case (state_q)
        cts_pkg::ST_DISCHARGE: begin
          if (dis_end) begin
            state_d = cts_pkg::ST_CHARGE;
          end
        end
        cts_pkg::ST_CHARGE: begin
          if (comp_sync_q) begin
            state_d = cts_pkg::ST_IDLE;
          end
        end
        default: state_d = state_q;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= cts_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // discharge timer counts touch clocks
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dis_cnt_q <= 8'h00;
    end else if (state_q != cts_pkg::ST_DISCHARGE || cmd_wr) begin
      dis_cnt_q <= 8'h00;
    end else if (tick_q) begin
      dis_cnt_q <= dis_cnt_q + 8'h01;
    end
  end

  // touch counter; kept after done so software can read it
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_q <= cts_pkg::COUNT_RESET;
    end else if (start_cmd) begin
      count_q <= cts_pkg::COUNT_RESET;
    end else if (count_step) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // analog controls follow state_d so they switch with the state flop
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      discharge_o <= 1'b0;
    end else begin
      discharge_o <= (state_d == cts_pkg::ST_DISCHARGE) || (state_d == cts_pkg::ST_HOLD);
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      charge_o <= 1'b0;
    end else begin
      charge_o <= (state_d == cts_pkg::ST_CHARGE);
    end
  end

  // step lands on the same edge as the count; the front end only sees the pulse
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      charge_step_o <= 1'b0;
    end else begin
      charge_step_o <= count_step;
    end
  end

  // configuration registers, one per concern
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      power_q <= cts_pkg::POWER_RESET;
    end else if (reg_hit(wr_i, addr_i, cts_pkg::ADDR_POWER)) begin
      power_q <= wr_data_i;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pad_q <= cts_pkg::PAD_RESET;
    end else if (reg_hit(wr_i, addr_i, cts_pkg::ADDR_PAD)) begin
      pad_q <= wr_data_i;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      setting_q <= cts_pkg::SETTING_RESET;
    end else if (reg_hit(wr_i, addr_i, cts_pkg::ADDR_SETTING)) begin
      setting_q <= wr_data_i[4:0];
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      inten_q <= cts_pkg::INTEN_RESET;
    end else if (reg_hit(wr_i, addr_i, cts_pkg::ADDR_INTEN)) begin
      inten_q <= wr_data_i;
    end
  end

  // request flags: a set in the same cycle beats the software clear
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      intrq_q <= cts_pkg::INTRQ_RESET;
    end else begin
      if (reg_hit(wr_i, addr_i, cts_pkg::ADDR_INTRQ)) begin
        intrq_q <= intrq_q & wr_data_i;
      end
      if (done_evt) begin
        intrq_q[cts_pkg::IRQ_DONE_BIT] <= 1'b1;
      end
      if (ovf_evt) begin
        intrq_q[cts_pkg::IRQ_OVF_BIT] <= 1'b1;
      end
    end
  end

  // mirrored outputs, each from its own flop
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pad_select_o <= cts_pkg::PAD_RESET;
    end else begin
      pad_select_o <= pad_q;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      threshold_sel_o <= 3'h0;
    end else begin
      threshold_sel_o <= setting_q[cts_pkg::SET_THR_LSB +: 3];
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bypass_o <= 1'b0;
      level_sel_o <= 1'b0;
    end else begin
      bypass_o <= power_q[cts_pkg::POWER_BYPASS_BIT];
      level_sel_o <= power_q[cts_pkg::POWER_LEVEL_BIT];
    end
  end

  // irq lags the flags by one cycle, the price of a flopped output
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (intrq_q[cts_pkg::IRQ_DONE_BIT] && inten_q[cts_pkg::IRQ_DONE_BIT]) ||
               (intrq_q[cts_pkg::IRQ_OVF_BIT] && inten_q[cts_pkg::IRQ_OVF_BIT]);
    end
  end

  // read port; unmapped offsets read zero, data only in the next cycle
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        cts_pkg::ADDR_POWER: rd_data_o <= {4'h0, power_q[3:2], 2'h0};
        cts_pkg::ADDR_PAD: rd_data_o <= pad_q;
        cts_pkg::ADDR_CMD: rd_data_o <= {6'h00, state_q};
        cts_pkg::ADDR_SETTING: rd_data_o <= {3'h0, setting_q};
        cts_pkg::ADDR_CNT_HI: rd_data_o <= count_q[15:8];
        cts_pkg::ADDR_CNT_LO: rd_data_o <= count_q[7:0];
        cts_pkg::ADDR_INTEN: rd_data_o <= inten_q & 8'h28;
        cts_pkg::ADDR_INTRQ: rd_data_o <= intrq_q;
        default: rd_data_o <= 8'h00;
      endcase
    end else begin
      rd_data_o <= 8'h00;
    end
  end

endmodule : cts_sequencer

// ==== testbench/cts_sequencer_checker.sv ====
// port assertions for the touch sequencer
`timescale 1ns/10ps
module cts_sequencer_checker (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic comp_trip_i,
  input wire logic [7:0] rd_data_o,
  input wire logic discharge_o,
  input wire logic charge_o,
  input wire logic charge_step_o,
  input wire logic [2:0] threshold_sel_o,
  input wire logic bypass_o,
  input wire logic level_sel_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  wire logic cmd_w = wr_i && addr_i == cts_pkg::ADDR_CMD;
  wire logic [2:0] thr_w = wr_data_i[4:2];
  wire logic [1:0] pow_w = wr_data_i[3:2];
  logic hold_q;
  // hold lasts from a manual command until a start or an abort
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_q <= 1'b0;
    end else if (cmd_w && wr_data_i == cts_pkg::CMD_MANUAL) begin
      hold_q <= 1'b1;
    end else if (cmd_w && (wr_data_i == cts_pkg::CMD_START || wr_data_i == cts_pkg::CMD_ABORT)) begin
      hold_q <= 1'b0;
    end
  end
  // start from hold skips discharge, so only idle or charge is checked
  start_disch_a: assert property (cmd_w && wr_data_i == cts_pkg::CMD_START && !discharge_o |=> discharge_o && !charge_o)
    else $error("start gave no discharge");
  manual_hold_a: assert property (hold_q |-> discharge_o && !charge_o)
    else $error("manual hold lost");
  abort_idle_a: assert property (cmd_w && wr_data_i == cts_pkg::CMD_ABORT |=> !discharge_o && !charge_o)
    else $error("abort not idle");
  step_pulse_a: assert property (charge_step_o |=> !charge_step_o [*3])
    else $error("step faster than touch clock");
  trip_stop_a: assert property (charge_o && comp_trip_i |-> ##[1:6] !charge_o)
    else $error("charge kept after trip");
  thr_sel_a: assert property (wr_i && addr_i == cts_pkg::ADDR_SETTING |=> ##1 threshold_sel_o == $past(thr_w, 2))
    else $error("threshold select wrong");
  rd_idle_a: assert property (!$past(rd_i) |-> rd_data_o == 8'h00)
    else $error("read data outside slot");
  power_sel_a: assert property (wr_i && addr_i == cts_pkg::ADDR_POWER |=> ##1 {level_sel_o, bypass_o} == $past(pow_w, 2))
    else $error("power select wrong");
endmodule : cts_sequencer_checker
bind cts_sequencer cts_sequencer_checker i_cts_sequencer_checker (.clock_i, .sys_rst_i, .addr_i, .wr_data_i, .wr_i,
  .rd_i, .comp_trip_i, .rd_data_o, .discharge_o, .charge_o, .charge_step_o, .threshold_sel_o, .bypass_o, .level_sel_o);

// ==== testbench/cts_front_end.sv ====
// sense capacitor and comparator model
`timescale 1ns/10ps
module cts_front_end (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic charge_i,
  input wire logic charge_step_i,
  input wire logic [15:0] steps_i,
  output logic comp_trip_o
);
  // the shared pin is always the sense capacitor pin here
  logic [15:0] level_q;
  // capacitor is held at ground whenever not charging
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      level_q <= 16'h0000;
    end else begin
      level_q <= charge_i ? level_q + 16'(charge_step_i) : 16'h0000;
    end
  end
  assign comp_trip_o = charge_i && level_q >= steps_i;
endmodule : cts_front_end

// ==== testbench/testbench.sv ====
// self-checking bench for the touch sequencer
`timescale 1ns/10ps
module testbench;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic comp_trip_i, discharge_o, charge_o, charge_step_o, bypass_o, level_sel_o, irq_o;
  logic [7:0] rd_data_o, pad_select_o, d;
  logic [2:0] threshold_sel_o;
  logic [15:0] tgt = 16'h0010;
  logic [15:0] dis_cyc = 16'h0000;
  logic [15:0] stp = 16'h0000;
  int n_errors = 0;
  int n_checks = 0;
  cts_sequencer i_cts_sequencer (.clock_i, .sys_rst_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .comp_trip_i, .rd_data_o,
    .pad_select_o, .discharge_o, .charge_o, .charge_step_o, .threshold_sel_o, .bypass_o, .level_sel_o, .irq_o);
  cts_front_end i_cts_front_end (.clock_i, .sys_rst_i, .charge_i(charge_o), .charge_step_i(charge_step_o),
    .steps_i(tgt), .comp_trip_o(comp_trip_i));
  initial forever #5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    dis_cyc <= dis_cyc + 16'(discharge_o);
    stp <= stp + 16'(charge_step_o);
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock_i) {addr_i, wr_data_i, wr_i} <= {a, v, 1'b1};
    @(posedge clock_i) wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clock_i) {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clock_i) rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask : rd
  task automatic reset_power;
    for (int a = 0; a < 9; a++) begin
      rd(4'(a));
      check("reset", 16'h0000, 16'(d));
    end
    wr(cts_pkg::ADDR_POWER, 8'h0C);
    #12 check("power", 16'h0003, 16'({level_sel_o, bypass_o}));
    wr(cts_pkg::ADDR_POWER, 8'h08);
    rd(cts_pkg::ADDR_POWER);
    check("power rd", 16'h0008, 16'(d));
    check("regulator", 16'h0002, 16'({level_sel_o, bypass_o}));
  endtask : reset_power
  task automatic measure(input logic [1:0] dc, input logic [2:0] thr, input logic [7:0] en, input int nd);
    logic [15:0] d0, s0, cnt;
    wr(cts_pkg::ADDR_PAD, 8'h01);
    wr(cts_pkg::ADDR_SETTING, {3'h0, thr, dc});
    wr(cts_pkg::ADDR_INTEN, en);
    check("pad", 16'h0001, 16'(pad_select_o));
    d0 = dis_cyc;
    s0 = stp;
    wr(cts_pkg::ADDR_CMD, cts_pkg::CMD_START);
    rd(cts_pkg::ADDR_CMD);
    for (int i = 0; i < 900 && d !== 8'h00; i++) rd(cts_pkg::ADDR_CMD);
    check("state", 16'h0000, 16'(d));
    // tick phase is free running, so the length is judged to within 16 cycles
    check("disch", 16'(nd >> 3), (dis_cyc - d0 + 16'h0010) >> 5);
    rd(cts_pkg::ADDR_CNT_HI);
    rd(cts_pkg::ADDR_CNT_HI);
    cnt[15:8] = d;
    rd(cts_pkg::ADDR_CNT_LO);
    cnt[7:0] = d;
    check("count", stp - s0, cnt);
    check("steps", tgt, cnt);
    check("thr", 16'(thr), 16'(threshold_sel_o));
    check("irq", 16'(en[3]), 16'(irq_o));
    rd(cts_pkg::ADDR_INTRQ);
    check("req", 16'h0008, 16'(d));
    wr(cts_pkg::ADDR_INTRQ, 8'h00);
    rd(cts_pkg::ADDR_INTRQ);
    check("clr", 16'h0000, 16'(d));
    check("irq off", 16'h0000, 16'(irq_o));
  endtask : measure
  task automatic manual_abort;
    tgt <= 16'hFFFF;
    wr(cts_pkg::ADDR_CMD, cts_pkg::CMD_MANUAL);
    repeat (20) @(posedge clock_i);
    wr(cts_pkg::ADDR_CMD, 8'h55);
    rd(cts_pkg::ADDR_CMD);
    check("hold", 16'h0002, 16'(d));
    wr(cts_pkg::ADDR_CMD, cts_pkg::CMD_START);
    #12 check("go", 16'h0001, 16'({discharge_o, charge_o}));
    wr(cts_pkg::ADDR_CMD, cts_pkg::CMD_ABORT);
    rd(cts_pkg::ADDR_CMD);
    check("abort", 16'h0000, 16'({d, discharge_o, charge_o}));
  endtask : manual_abort
  task automatic stop_test;
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (8) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    reset_power;
    measure(2'h0, 3'h7, 8'h08, 32);
    measure(2'h1, 3'h1, 8'h00, 64);
    measure(2'h3, 3'h3, 8'h28, 128);
    measure(2'h2, 3'h5, 8'h20, 128);
    manual_abort;
    stop_test;
  end
  initial begin
    #60000;
    n_errors++;
    stop_test;
  end
endmodule : testbench
